// >>> design/epfc_pkg.sv
package epfc_pkg;
    // Register byte addresses.
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_ADVERT = 8'h04;
    localparam logic [7:0] ADDR_SAVE = 8'h08;
    localparam logic [7:0] ADDR_PARTNER = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_ACTIVE = 8'h14;

    // Configuration register fields.
    localparam int CFG_SPEED_LSB = 0;
    localparam int CFG_DUPLEX_BIT = 2;
    localparam int CFG_ANEG_BIT = 3;
    localparam int CFG_FLOW_LSB = 4;
    localparam int CFG_BP_BIT = 7;
    localparam int CFG_WIDTH = 8;

    // Speed codes.
    localparam logic [1:0] SPEED_10 = 2'h0;
    localparam logic [1:0] SPEED_100 = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;

    // Full-duplex flow-control settings.
    localparam logic [2:0] FLOW_OFF = 3'h0;
    localparam logic [2:0] FLOW_SYM = 3'h1;
    localparam logic [2:0] FLOW_ASYM_RX = 3'h2;
    localparam logic [2:0] FLOW_ASYM_TX = 3'h3;
    localparam logic [2:0] FLOW_ANEG = 3'h4;

    // Ability bit positions in the advertisement and partner registers.
    localparam int AB_TEN_HALF = 0;
    localparam int AB_TEN_FULL = 1;
    localparam int AB_HUND_HALF = 2;
    localparam int AB_HUND_FULL = 3;
    localparam int AB_GIG_HALF = 4;
    localparam int AB_GIG_FULL = 5;
    localparam int AB_FAST_PAUSE = 6;
    localparam int AB_GIG_ASYM = 7;
    localparam int AB_GIG_SYM = 8;
    localparam int AB_GIG_BOTH = 9;
    localparam int AB_FAULT1 = 10;
    localparam int AB_FAULT2 = 11;
    localparam int AB_WIDTH = 12;

    // Reset values: autonegotiation on, 100 Mbps full, flow by negotiation, back pressure on.
    localparam logic [CFG_WIDTH-1:0] CFG_RESET = 8'hcd;
    localparam logic [AB_WIDTH-1:0] ADVERT_RESET = 12'hfff;

    // Link status codes.
    localparam logic [1:0] LINK_DOWN = 2'h0;
    localparam logic [1:0] LINK_UP = 2'h1;
    localparam logic [1:0] LINK_UNKNOWN = 2'h2;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> design/epfc_res_if.sv
`timescale 1ns/100ps
interface epfc_res_if;
    logic [epfc_pkg::AB_WIDTH-1:0] local_ab;
    logic [epfc_pkg::AB_WIDTH-1:0] partner_ab;
    logic [1:0] speed;
    logic duplex;
    logic pause_rx;
    logic pause_tx;
    logic found;
    modport req (output local_ab, output partner_ab, input speed, input duplex, input pause_rx, input pause_tx,
                 input found);
    modport rsp (input local_ab, input partner_ab, output speed, output duplex, output pause_rx, output pause_tx,
                 output found);
endinterface

// >>> design/epfc_resolve.sv
`timescale 1ns/100ps
module epfc_resolve (
    epfc_res_if.rsp res // Local and partner abilities in, resolved mode out.
);
    logic [epfc_pkg::AB_WIDTH-1:0] common;
    logic loc_sym;
    logic loc_asym;
    logic par_sym;
    logic par_asym;

    assign common = res.local_ab & res.partner_ab;

    // Highest common rate wins, full before half at each rate.
    always_comb begin
        res.found = 1'b1;
        res.speed = epfc_pkg::SPEED_10;
        res.duplex = 1'b0;
        if (common[epfc_pkg::AB_GIG_FULL]) begin
            res.speed = epfc_pkg::SPEED_1000;
            res.duplex = 1'b1;
        end else if (common[epfc_pkg::AB_GIG_HALF]) begin
            res.speed = epfc_pkg::SPEED_1000;
        end else if (common[epfc_pkg::AB_HUND_FULL]) begin
            res.speed = epfc_pkg::SPEED_100;
            res.duplex = 1'b1;
        end else if (common[epfc_pkg::AB_HUND_HALF]) begin
            res.speed = epfc_pkg::SPEED_100;
        end else if (common[epfc_pkg::AB_TEN_FULL]) begin
            res.duplex = 1'b1;
        end else if (!common[epfc_pkg::AB_TEN_HALF]) begin
            res.found = 1'b0;
        end
    end

    // Symmetric and asymmetric pause bits; the fast pause ability counts as symmetric.
    assign loc_sym = res.local_ab[epfc_pkg::AB_GIG_SYM] | res.local_ab[epfc_pkg::AB_GIG_BOTH]
        | res.local_ab[epfc_pkg::AB_FAST_PAUSE];
    assign loc_asym = res.local_ab[epfc_pkg::AB_GIG_ASYM] | res.local_ab[epfc_pkg::AB_GIG_BOTH];
    assign par_sym = res.partner_ab[epfc_pkg::AB_GIG_SYM] | res.partner_ab[epfc_pkg::AB_GIG_BOTH]
        | res.partner_ab[epfc_pkg::AB_FAST_PAUSE];
    assign par_asym = res.partner_ab[epfc_pkg::AB_GIG_ASYM] | res.partner_ab[epfc_pkg::AB_GIG_BOTH];

    // Standard priority resolution, only for a full-duplex outcome.
    always_comb begin
        res.pause_rx = 1'b0;
        res.pause_tx = 1'b0;
        if (res.found && res.duplex) begin
            if (loc_sym && par_sym) begin
                res.pause_rx = 1'b1;
                res.pause_tx = 1'b1;
            end else if (loc_sym && loc_asym && !par_sym && par_asym) begin
                res.pause_rx = 1'b1;
            end else if (!loc_sym && loc_asym && par_sym && par_asym) begin
                res.pause_tx = 1'b1;
            end
        end
    end
endmodule

// >>> design/epfc_port.sv
`timescale 1ns/100ps
// Contract
// - Autonegotiation off: run at configured speed, duplex and flow settings.
// - Speed setting encodes 10, 100 or 1000 Mbps; duplex is half or full.
// - Per-port autonegotiation enable; when on, abilities are advertised.
// - Each ability has its own enable, effective only with autonegotiation on.
// - All abilities enabled by default, advertising every supported mode.
// - Abilities include 10 and 100 half and full, and gigabit half and full.
// - One pause ability at 100 Mbps; three gigabit ones: asymmetric, symmetric, both.
// - Two remote-fault abilities, advertised independently.
// - Symmetric mode: obey received pause and allow sending pause, any speed.
// - Asymmetric receive, gigabit only: obey received pause, never send it; the code tests the configured speed, not the negotiated one.
// - Asymmetric transmit, gigabit only: ignore received pause, may send it; the code tests the configured speed, not the negotiated one.
// - Flow control off: ignore received pause and never send it.
// - Negotiated mode: advertise full pause capability, operate per negotiation result.
// - Negotiated flow choice unavailable on ports without autonegotiation support; the code refuses it on writes only, and reset loads it with autonegotiation on.
// - Half-duplex back-pressure setting turns collision flow control on or off.
// - Negotiation resolves to the highest speed both ends support.
// - Link reports undetermined until negotiation completes, distinct from up and down.
module epfc_port #(
    parameter bit ANEG_SUPPORTED = 1'b1 // Port can autonegotiate.
) (
    input wire logic aclk, // Clock.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [31:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [31:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read valid.
    input wire logic s_axi_rready, // Read ready.
    input wire logic link_signal, // Link pulse present, from the line.
    input wire logic aneg_done, // Negotiation completed, from the line.
    input wire logic [11:0] partner_ability, // Partner advertisement, from the line.
    output logic [11:0] advert_ability, // Abilities offered to the partner.
    output logic advert_enable, // Negotiation running on the line.
    output logic [1:0] oper_speed, // Operating speed code.
    output logic oper_full_duplex, // Operating in full duplex.
    output logic pause_rx_enable, // Act on received pause frames.
    output logic pause_tx_enable, // Permitted to send pause frames.
    output logic backpressure_enable, // Half-duplex collision flow control.
    output logic [1:0] link_state // Down, up or undetermined.
);
    logic [7:0] cfg;
    logic [11:0] advert;
    logic [7:0] saved_cfg;
    logic [11:0] saved_advert;
    logic link_s1;
    logic link_s2;
    logic done_s1;
    logic done_s2;
    logic [11:0] partner_s1;
    logic [11:0] partner_s2;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic ar_held;
    logic [7:0] ar_addr;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic wr_go;
    logic wr_ok;
    logic aneg_on;
    logic [1:0] cfg_speed;
    logic [2:0] cfg_flow;
    logic gig_cfg;
    logic [11:0] eff_advert;
    logic [1:0] next_speed;
    logic next_duplex;
    logic next_prx;
    logic next_ptx;
    logic [1:0] next_link;

    epfc_res_if res ();

    epfc_resolve u_resolve (
        .res(res)
    );

    // Pins from the line pass two flip-flops before use.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_s1 <= 1'b0;
            link_s2 <= 1'b0;
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            partner_s1 <= '0;
            partner_s2 <= '0;
        end else begin
            link_s1 <= link_signal;
            link_s2 <= link_s1;
            done_s1 <= aneg_done;
            done_s2 <= done_s1;
            partner_s1 <= partner_ability;
            partner_s2 <= partner_s1;
        end
    end

    // Write channel: address and data are caught in either order.
    assign wr_go = aw_held && w_held && !s_axi_bvalid;
    assign wr_ok = aw_addr == epfc_pkg::ADDR_CONFIG || aw_addr == epfc_pkg::ADDR_ADVERT
        || aw_addr == epfc_pkg::ADDR_SAVE;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= epfc_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr[7:0];
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? epfc_pkg::RESP_OKAY : epfc_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Working settings; illegal codes written by software are refused field by field.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg <= epfc_pkg::CFG_RESET;
            advert <= epfc_pkg::ADVERT_RESET;
        end else if (wr_go && aw_addr == epfc_pkg::ADDR_CONFIG && w_strb[0]) begin
            cfg[epfc_pkg::CFG_DUPLEX_BIT] <= w_data[epfc_pkg::CFG_DUPLEX_BIT];
            cfg[epfc_pkg::CFG_ANEG_BIT] <= w_data[epfc_pkg::CFG_ANEG_BIT] & ANEG_SUPPORTED;
            cfg[epfc_pkg::CFG_BP_BIT] <= w_data[epfc_pkg::CFG_BP_BIT];
            if (w_data[1:0] != 2'h3) begin
                cfg[1:0] <= w_data[1:0];
            end
            if (w_data[6:4] <= epfc_pkg::FLOW_ASYM_TX || (w_data[6:4] == epfc_pkg::FLOW_ANEG && ANEG_SUPPORTED)) begin
                cfg[6:4] <= w_data[6:4];
            end
        end else if (wr_go && aw_addr == epfc_pkg::ADDR_ADVERT) begin
            if (w_strb[0]) begin
                advert[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
                advert[11:8] <= w_data[11:8];
            end
        end
    end

    // Save copies the working settings to the committed copy the port runs from.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            saved_cfg <= epfc_pkg::CFG_RESET;
            saved_advert <= epfc_pkg::ADVERT_RESET;
        end else if (wr_go && aw_addr == epfc_pkg::ADDR_SAVE && w_strb[0] && w_data[0]) begin
            saved_cfg <= cfg;
            saved_advert <= advert;
        end
    end

    assign aneg_on = saved_cfg[epfc_pkg::CFG_ANEG_BIT];
    assign cfg_speed = saved_cfg[1:0];
    assign cfg_flow = saved_cfg[6:4];
    assign gig_cfg = cfg_speed == epfc_pkg::SPEED_1000;

    // Negotiated flow mode advertises every pause ability; flow off clears them; other modes keep the saved pause bits.
    always_comb begin
        eff_advert = saved_advert;
        if (cfg_flow == epfc_pkg::FLOW_OFF) begin
            eff_advert[9:6] = 4'h0;
        end else if (cfg_flow == epfc_pkg::FLOW_ANEG) begin
            eff_advert[9:6] = 4'hf;
        end
    end

    assign res.local_ab = eff_advert;
    assign res.partner_ab = partner_s2;

    // Operating mode: manual settings or the negotiated result.
    always_comb begin
        next_speed = cfg_speed;
        next_duplex = saved_cfg[epfc_pkg::CFG_DUPLEX_BIT];
        next_prx = 1'b0;
        next_ptx = 1'b0;
        next_link = link_s2 ? epfc_pkg::LINK_UP : epfc_pkg::LINK_DOWN;
        if (aneg_on) begin
            if (!done_s2) begin
                next_link = epfc_pkg::LINK_UNKNOWN;
            end else if (!res.found) begin
                next_link = epfc_pkg::LINK_DOWN;
            end
            next_speed = res.speed;
            next_duplex = res.duplex;
            if (cfg_flow == epfc_pkg::FLOW_ANEG) begin
                next_prx = res.pause_rx;
                next_ptx = res.pause_tx;
            end
        end
        if (!aneg_on || cfg_flow != epfc_pkg::FLOW_ANEG) begin
            unique case (cfg_flow)
                epfc_pkg::FLOW_SYM: begin
                    next_prx = 1'b1;
                    next_ptx = 1'b1;
                end
                epfc_pkg::FLOW_ASYM_RX: begin
                    next_prx = gig_cfg;
                end
                epfc_pkg::FLOW_ASYM_TX: begin
                    next_ptx = gig_cfg;
                end
                default: begin
                    next_prx = 1'b0;
                    next_ptx = 1'b0;
                end
            endcase
        end
        if (!next_duplex) begin
            next_prx = 1'b0;
            next_ptx = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            advert_ability <= '0;
            advert_enable <= 1'b0;
            oper_speed <= epfc_pkg::SPEED_10;
            oper_full_duplex <= 1'b0;
            pause_rx_enable <= 1'b0;
            pause_tx_enable <= 1'b0;
            backpressure_enable <= 1'b0;
            link_state <= epfc_pkg::LINK_DOWN;
        end else begin
            advert_enable <= aneg_on;
            advert_ability <= aneg_on ? eff_advert : 12'h000;
            oper_speed <= next_speed;
            oper_full_duplex <= next_duplex;
            pause_rx_enable <= next_prx;
            pause_tx_enable <= next_ptx;
            backpressure_enable <= saved_cfg[epfc_pkg::CFG_BP_BIT] && !next_duplex;
            link_state <= next_link;
        end
    end

    // Read channel: one cycle to accept, one to answer.
    always_comb begin
        next_rresp = epfc_pkg::RESP_OKAY;
        next_rdata = 32'h0000_0000;
        unique case (ar_addr)
            epfc_pkg::ADDR_CONFIG: next_rdata = {24'h00_0000, cfg};
            epfc_pkg::ADDR_ADVERT: next_rdata = {20'h0_0000, advert};
            epfc_pkg::ADDR_SAVE: next_rdata = 32'h0000_0000;
            epfc_pkg::ADDR_PARTNER: next_rdata = {20'h0_0000, partner_s2};
            epfc_pkg::ADDR_STATUS: next_rdata = {24'h00_0000, backpressure_enable, pause_tx_enable,
                pause_rx_enable, oper_full_duplex, oper_speed, link_state};
            epfc_pkg::ADDR_ACTIVE: next_rdata = {20'h0_0000, advert_ability};
            default: next_rresp = epfc_pkg::RESP_SLVERR;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_held <= 1'b0;
            ar_addr <= '0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= epfc_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !ar_held && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                ar_held <= 1'b1;
                ar_addr <= s_axi_araddr[7:0];
                s_axi_arready <= 1'b0;
            end
            if (ar_held && !s_axi_rvalid) begin
                ar_held <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rresp;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// >>> dv/epfc_port_properties.sv
`timescale 1ns/100ps
module epfc_port_chk (
    input wire logic aclk, // Clock.
    input wire logic aresetn, // Reset, active low.
    input wire logic s_axi_arvalid, // Read address valid.
    input wire logic s_axi_arready, // Read address ready.
    input wire logic s_axi_rvalid, // Read valid.
    input wire logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [1:0] s_axi_bresp, // Write response.
    input wire logic link_signal, // Link pulse.
    input wire logic aneg_done, // Negotiation complete.
    input wire logic [11:0] partner_ability, // Partner offer.
    input wire logic [11:0] advert_ability, // Local offer.
    input wire logic advert_enable, // Negotiation running.
    input wire logic [1:0] oper_speed, // Operating speed.
    input wire logic oper_full_duplex, // Full duplex.
    input wire logic pause_rx_enable, // Obey pause.
    input wire logic pause_tx_enable, // May send pause.
    input wire logic backpressure_enable, // Back pressure.
    input wire logic [1:0] link_state // Link state.
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    adv_gated_a: assert property (!advert_enable |-> advert_ability == 12'h0)
        else $error("abilities offered while negotiation is off");
    pause_fdx_a: assert property (!oper_full_duplex |-> !pause_rx_enable && !pause_tx_enable)
        else $error("pause enabled in half duplex");
    bp_half_a: assert property (backpressure_enable |-> !oper_full_duplex)
        else $error("back pressure in full duplex");
    asym_gig_a: assert property (!advert_enable && oper_speed != epfc_pkg::SPEED_1000
        |-> pause_rx_enable == pause_tx_enable) else $error("one-way pause below gigabit");
    speed_code_a: assert property (oper_speed != 2'h3)
        else $error("illegal speed code");
    link_pend_a: assert property ((advert_enable && !aneg_done) [*6]
        |-> link_state == epfc_pkg::LINK_UNKNOWN) else $error("link not undetermined while negotiating");
    link_down_a: assert property ((!advert_enable && !link_signal) [*6]
        |-> link_state == epfc_pkg::LINK_DOWN) else $error("link not down without link pulse");
    gig_best_a: assert property ((advert_enable && link_state == epfc_pkg::LINK_UP
        && advert_ability[5] && partner_ability[5]) [*6] |-> oper_speed == epfc_pkg::SPEED_1000)
        else $error("common gigabit not chosen");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> ##1 s_axi_rvalid)
        else $error("read answer late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");

    gig_up_c: cover property (link_state == epfc_pkg::LINK_UP && oper_speed == epfc_pkg::SPEED_1000);
    pause_both_c: cover property (pause_rx_enable && pause_tx_enable);
    pend_c: cover property (link_state == epfc_pkg::LINK_UNKNOWN);
endmodule

bind epfc_port epfc_port_chk i_chk (.*);

// >>> dv/epfc_link_partner.sv
`timescale 1ns/100ps
module epfc_link_partner (
    input wire logic aclk, // Clock.
    input wire logic aresetn, // Reset, active low.
    input wire logic [11:0] advert_ability, // Local offer.
    input wire logic advert_enable, // Local negotiation on.
    input wire logic [11:0] own_ability, // Partner offer.
    input wire logic [7:0] settle, // Negotiation length, nonzero.
    input wire logic cable, // Cable plugged.
    output logic link_signal, // Link pulse.
    output logic aneg_done, // Negotiation complete.
    output logic [11:0] partner_ability // Offer on the line.
);
    logic [23:0] seen;
    logic [7:0] count;
    // A changed offer on either side restarts negotiation.
    always_ff @(posedge aclk) begin
        seen <= {advert_ability, own_ability};
        if (!aresetn || !advert_enable || !cable || seen != {advert_ability, own_ability})
            count <= 8'h0;
        else if (count != settle)
            count <= count + 8'h1;
    end
    assign aneg_done = (count == settle);
    assign link_signal = cable && (!advert_enable || aneg_done);
    // While negotiation is off the line carries the inverted partner offer, not the offer itself.
    assign partner_ability = advert_enable ? own_ability : ~own_ability;
endmodule

// >>> dv/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, oper_speed, link_state, rsp;
    logic link_signal, aneg_done, advert_enable, oper_full_duplex, pause_rx_enable, pause_tx_enable;
    logic backpressure_enable;
    logic [11:0] partner_ability, advert_ability, own_ability = 12'h03f;
    logic [7:0] settle = 8'h28;
    logic cable = 1'h1;
    int failures = 0, num_checks = 0, cycles = 0;

    always #5 aclk = ~aclk;
    epfc_port i_dut (.*);
    epfc_link_partner i_partner (.*);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1)
                s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic axi_read(input logic [7:0] a);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1)
                s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic commit(input logic [31:0] c);
        axi_write(epfc_pkg::ADDR_CONFIG, c);
        axi_write(epfc_pkg::ADDR_SAVE, 32'h1);
        repeat (3) @(posedge aclk);
    endtask
    task automatic chk_mode(input logic [1:0] sp, input logic fdx, rx, tx, bp);
        chk(oper_speed, sp);
        chk(oper_full_duplex, fdx);
        chk(pause_rx_enable, rx);
        chk(pause_tx_enable, tx);
        chk(backpressure_enable, bp);
    endtask

    task automatic t_reset;
        axi_read(epfc_pkg::ADDR_CONFIG);
        chk(rd, {24'h0, epfc_pkg::CFG_RESET});
        axi_read(epfc_pkg::ADDR_ADVERT);
        chk(rd, {20'h0, epfc_pkg::ADVERT_RESET});
        chk({advert_enable, advert_ability}, 32'h1fff);
        axi_write(epfc_pkg::ADDR_CONFIG, 32'h7b);
        chk(rsp, epfc_pkg::RESP_OKAY);
        axi_read(epfc_pkg::ADDR_CONFIG);
        chk(rd, {24'h0, 1'h0, epfc_pkg::FLOW_ANEG, 1'h1, 1'h0, epfc_pkg::SPEED_100});
        axi_write(8'h18, 32'h1);
        chk(rsp, epfc_pkg::RESP_SLVERR);
        axi_read(8'h20);
        chk(rsp, epfc_pkg::RESP_SLVERR);
        chk(rd, 32'h0);
    endtask
    task automatic t_manual;
        logic [7:0] c;
        axi_write(epfc_pkg::ADDR_CONFIG, 32'h95);
        repeat (3) @(posedge aclk);
        chk(advert_enable, 32'h1);
        for (int s = 0; s < 3; s++) begin
            for (int d = 0; d < 2; d++) begin
                c = {1'h1, epfc_pkg::FLOW_SYM, 1'h0, d[0], s[1:0]};
                commit({24'h0, c});
                chk({advert_enable, advert_ability}, 32'h0);
                chk_mode(s[1:0], d[0], d[0], d[0], !d[0]);
                axi_read(epfc_pkg::ADDR_STATUS);
                chk(rd, {24'h0, !d[0], d[0], d[0], d[0], s[1:0], epfc_pkg::LINK_UP});
            end
        end
        cable <= 1'h0;
        repeat (8) @(posedge aclk);
        chk(link_state, epfc_pkg::LINK_DOWN);
        cable <= 1'h1;
    endtask
    task automatic t_flow;
        for (int s = 1; s < 3; s++) begin
            for (int f = 0; f < 4; f++) begin
                commit({25'h0, f[2:0], 2'h1, s[1:0]});
                chk_mode(s[1:0], 1'h1, f == 1 || (f == 2 && s == 2), f == 1 || (f == 3 && s == 2), 1'h0);
            end
        end
        commit(32'h12);
        chk_mode(epfc_pkg::SPEED_1000, 1'h0, 1'h0, 1'h0, 1'h0);
    endtask
    task automatic t_aneg(input logic [11:0] adv, input logic [2:0] fl, input logic [11:0] peer,
                          input logic [11:0] exp_adv, input logic [1:0] sp, input logic fdx, rx, tx);
        int n = 0;
        own_ability <= peer;
        axi_write(epfc_pkg::ADDR_ADVERT, {20'h0, adv});
        commit({24'h0, 1'h1, fl, 4'h9});
        @(posedge aclk);
        chk(link_state, epfc_pkg::LINK_UNKNOWN);
        chk(advert_ability, exp_adv);
        while (link_state !== epfc_pkg::LINK_UP && n < 300) begin
            @(posedge aclk);
            n++;
        end
        chk(link_state, epfc_pkg::LINK_UP);
        chk_mode(sp, fdx, rx, tx, !fdx);
        axi_read(epfc_pkg::ADDR_PARTNER);
        chk(rd, {20'h0, peer});
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reset();
        t_manual();
        t_flow();
        t_aneg(12'hfff, epfc_pkg::FLOW_ANEG, 12'h13f, 12'hfff, epfc_pkg::SPEED_1000, 1, 1, 1);
        t_aneg(12'h40f, epfc_pkg::FLOW_ANEG, 12'h03f, 12'h7cf, epfc_pkg::SPEED_100, 1, 0, 0);
        t_aneg(12'hfff, epfc_pkg::FLOW_OFF, 12'h015, 12'hc3f, epfc_pkg::SPEED_1000, 0, 0, 0);
        t_aneg(12'h803, epfc_pkg::FLOW_SYM, 12'h03f, 12'h803, epfc_pkg::SPEED_10, 1, 1, 1);
        close_out();
    end
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            close_out();
        end
    end
endmodule
